// ===== test/cbr_can_node_model.sv
// behavioural model of the other bus nodes: bit timing and bus level
module cbr_can_node_model (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // bench control
  input  wire logic domReq,
  // bus view
  output logic      bitTick,
  output logic      rxBit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] divCnt_ff;
  // one bit time every four clocks; a quiet bus reads recessive like a pulled-up line
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      divCnt_ff <= 2'h0;
      bitTick   <= 1'b0;
      rxBit     <= 1'b1;
    end else begin
      divCnt_ff <= divCnt_ff + 2'h1;
      bitTick   <= (divCnt_ff == 2'h3);
      rxBit     <= ~domReq;  // runs of recessive bits form idle conditions
    end
  end
endmodule : cbr_can_node_model

// ===== test/test_can_busoff_recovery.sv
// self-checking bench for bus-off recovery and flag priority
module test_can_busoff_recovery import cbr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IB = 3;
  localparam int IC = 2;
  localparam int RT = IB * IC + 1;  // bit ticks from the dominant restart of the idle run to bus-off low
  logic sys_clk = 0, reset = 1, bitTick, rxBit, domReq = 0, frameDone = 0, txErrInc = 0, rxErrInc = 0;
  logic rxMsgValid = 0, rxMsgAccept, txRequest = 0, txStart, initHoldClear = 0, peIrqClear = 0;
  logic peEn = 0, rxTimeoutSet = 0, rxTimeoutClear = 0, init_hold, peFlag, rxTo, irqRequest;
  cbr_status_t status;
  int miscompares = 0, checks_done = 0, cycles = 0, irqSeen = 0, txSeen = 0;
  logic [31:0] seed = 32'h189728d3;
  always #2 sys_clk = ~sys_clk;
  cbr_can_node_model i_node (.sys_clk(sys_clk), .reset(reset), .domReq(domReq), .bitTick(bitTick), .rxBit(rxBit));
  cbr_busoff_recovery #(.IDLE_BITS_P(IB), .IDLE_COUNT_P(IC)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .bitTick(bitTick), .rxBit(rxBit), .frameDone(frameDone),
    .txErrInc(txErrInc), .rxErrInc(rxErrInc), .rxMsgValid(rxMsgValid), .rxMsgAccept(rxMsgAccept),
    .txRequest(txRequest), .txStart(txStart), .initHoldClear(initHoldClear), .peIrqClear(peIrqClear),
    .protocol_error_irq_enable(peEn), .rxTimeoutSet(rxTimeoutSet), .rxTimeoutClear(rxTimeoutClear),
    .init_hold(init_hold), .status(status), .protocol_error_irq_flag(peFlag),
    .rx_timeout_event(rxTo), .irqRequest(irqRequest));
  // pulse counters and hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (irqRequest === 1'b1) irqSeen++;
    if (txStart === 1'b1) txSeen++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask : pulse
  // waits for a bit tick to be taken; clr lands a flag clear on that same edge
  task automatic tick(input bit clr);
    do @(negedge sys_clk); while (bitTick !== 1'b1);
    peIrqClear = clr;
    @(negedge sys_clk);
    peIrqClear = 1'b0;
  endtask : tick
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 0;
    peEn  = 1;
    tick(0);
    check(status.busActivityState, ACT_IDLE);
    domReq = 1;
    tick(0);
    domReq = 0;
    check(status.busActivityState, ACT_RX);
    rxMsgValid = 1;
    #1 check(rxMsgAccept, 1);
    rxMsgValid = 0;
    pulse(frameDone);
    pulse(initHoldClear);
    check(init_hold, 0);
    $display("test receive path done");
    pulse(rxErrInc);
    check(status.rxErrorCount, 1);
    // error strobe held up for 255 edges; the 256th edge passes the limit
    txErrInc = 1;
    repeat (255) @(negedge sys_clk);
    check(status.txErrorCount, 255);
    check(status.busoffFlag, 0);
    @(negedge sys_clk);
    txErrInc = 0;
    check({status.busoffFlag, init_hold, status.busActivityState}, {2'h3, ACT_SYNC});
    pulse(txRequest);
    // halted: hold stays up, random offers are refused, no transmit
    repeat (4) begin
      tick(0);
      seed = lfsr(seed);
      rxMsgValid = seed[0];
      #1 check({init_hold, status.busoffFlag, rxMsgAccept}, 3'h6);
    end
    check(txSeen, 0);
    $display("test bus-off entry done");
    pulse(initHoldClear);
    check(status.rxErrorCount, 0);
    // two recessive bits, then a dominant one cuts the idle run short
    repeat (2) tick(0);
    domReq = 1;
    tick(0);
    domReq = 0;
    check({status.busoffFlag, status.rxErrorCount}, {1'b1, 9'h0});
    for (int k = 1; k <= RT; k++) begin
      tick(k == 2 * IB);
      seed = lfsr(seed);
      rxMsgValid = seed[0];
      #1 check(status.busoffFlag, k < RT);
      if (k < RT) check({status.busActivityState, rxMsgAccept}, {ACT_SYNC, 1'b0});
      if (k == IB) check({status.rxErrorCount, status.lastErrorCode, peFlag}, {9'h1, LEC_BIT0_ERROR, 1'b1});
      if (k == 2 * IB) check(peFlag, 1);
    end
    rxMsgValid = 0;
    check({status.txErrorCount, status.rxErrorCount}, 0);
    check(irqSeen, 1);
    tick(0);
    check({status.busActivityState, txSeen[1:0]}, {ACT_IDLE, 2'h0});
    tick(0);
    check({status.busActivityState, txStart}, {ACT_TX, 1'b1});
    $display("test recovery done");
    @(negedge sys_clk);
    check(txSeen, 1);
    // keep clearing until the flag reads back low; the clear stays up while it is retried
    peIrqClear = 1'b1;
    repeat (4) begin
      @(negedge sys_clk);
      if (peFlag === 1'b0) break;
    end
    peIrqClear = 1'b0;
    check(peFlag, 0);
    pulse(rxTimeoutSet);
    check(rxTo, 1);
    @(negedge sys_clk);
    rxTimeoutClear = 1;
    pulse(rxTimeoutSet);
    rxTimeoutClear = 0;
    check({rxTo, irqSeen[1:0]}, 3'h1);
    $display("test flag priority done");
    end_sim();
  end
endmodule : test_can_busoff_recovery

// ===== verilog/cbr_busoff_recovery.sv
// bus-off entry, recovery sequencing and interrupt flag set/clear priority
module cbr_busoff_recovery
  import cbr_pkg::*;
#(
  parameter int IDLE_BITS_P  = IDLE_BITS,
  parameter int IDLE_COUNT_P = IDLE_COUNT
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // bit timing and bus, from the protocol engine (same clock)
  input  wire logic        bitTick,
  input  wire logic        rxBit,
  input  wire logic        frameDone,
  input  wire logic        txErrInc,
  input  wire logic        rxErrInc,
  // bus message interface
  input  wire logic        rxMsgValid,
  output logic             rxMsgAccept,
  input  wire logic        txRequest,
  output logic             txStart,
  // software controls
  input  wire logic        initHoldClear,
  input  wire logic        peIrqClear,
  input  wire logic        protocol_error_irq_enable,
  input  wire logic        rxTimeoutSet,
  input  wire logic        rxTimeoutClear,
  // status
  output logic             init_hold,
  output cbr_status_t      status,
  output logic             protocol_error_irq_flag,
  output logic             rx_timeout_event,
  output logic             irqRequest
);

  localparam int BW = $clog2(IDLE_BITS_P + 1);
  localparam int CW = $clog2(IDLE_COUNT_P + 1);
  localparam logic [BW-1:0] BITS_MAX = BW'(IDLE_BITS_P);
  localparam logic [CW-1:0] CNT_MAX  = CW'(IDLE_COUNT_P);
  localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 9'h001;
  localparam logic [CNT_W-1:0] TEC_LIM  = CNT_W'(BUSOFF_LIMIT);

  cbr_state_t       state_ff,   nxt_state;
  logic             hold_ff,    nxt_hold;
  logic             busoff_ff,  nxt_busoff;
  cbr_act_t         act_ff,     nxt_act;
  logic [2:0]       lec_ff,     nxt_lec;
  logic [CNT_W-1:0] tec_ff,     nxt_tec;
  logic [CNT_W-1:0] rec_ff,     nxt_rec;
  logic [BW-1:0]    recBits_ff, nxt_recBits;
  logic [CW-1:0]    idles_ff,   nxt_idles;
  logic             pea_ff,     nxt_pea;
  logic             rto_ff,     nxt_rto;
  logic             peaIrq_ff,  nxt_peaIrq;
  logic             txPend_ff,  nxt_txPend;
  logic             txStart_ff, nxt_txStart;
  logic             idleEvt;
  logic             recovering;

  // saturating increment used for both error counters
  function automatic logic [CNT_W-1:0] satInc(input logic [CNT_W-1:0] v);
    satInc = (v == {CNT_W{1'b1}}) ? v : v + CNT_ONE;
  endfunction : satInc

  assign recovering = (state_ff == ST_RECOVER);
  // one more idle condition seen: eleventh recessive bit in a row
  assign idleEvt = recovering && bitTick && rxBit && (recBits_ff == BITS_MAX - 1'b1);

  // protocol and recovery sequencer next state
  always_comb begin
    nxt_state   = state_ff;
    nxt_hold    = hold_ff;
    nxt_busoff  = busoff_ff;
    nxt_act     = act_ff;
    nxt_lec     = lec_ff;
    nxt_tec     = tec_ff;
    nxt_rec     = rec_ff;
    nxt_recBits = recBits_ff;
    nxt_idles   = idles_ff;
    nxt_txStart = 1'b0;
    nxt_txPend  = txPend_ff | txRequest;  // requests are held while not idle
    unique case (state_ff)
      ST_ACTIVE, ST_IDLE, ST_BUSY: begin
        if (txErrInc) nxt_tec = satInc(tec_ff);
        if (rxErrInc) nxt_rec = satInc(rec_ff);
        if (txErrInc && tec_ff >= TEC_LIM) begin  // count passes 255
          nxt_state  = ST_HALTED;
          nxt_busoff = 1'b1;
          nxt_hold   = 1'b1;
          nxt_act    = ACT_SYNC;
        end else if (state_ff == ST_ACTIVE && bitTick) begin
          nxt_state = ST_IDLE;
          nxt_act   = ACT_IDLE;
        end else if (state_ff == ST_IDLE && bitTick) begin
          // idle lasted a whole bit before leaving it
          if (!rxBit) begin
            nxt_state = ST_BUSY;
            nxt_act   = ACT_RX;
          end else if (txPend_ff) begin
            nxt_state   = ST_BUSY;
            nxt_act     = ACT_TX;
            nxt_txStart = 1'b1;
            nxt_txPend  = txRequest;
          end
        end else if (state_ff == ST_BUSY && frameDone) begin
          nxt_state = ST_ACTIVE;
        end
      end
      ST_HALTED: begin
        // nothing moves until software drops the hold
        if (initHoldClear) begin
          nxt_hold    = 1'b0;
          nxt_state   = ST_RECOVER;
          nxt_rec     = CNT_ZERO;
          nxt_recBits = '0;
          nxt_idles   = '0;
        end
      end
      ST_RECOVER: begin
        nxt_act = ACT_SYNC;                       // synchronizing, flag kept
        if (bitTick) begin
          if (!rxBit) nxt_recBits = '0;           // dominant bit restarts the idle run
          else if (idleEvt) nxt_recBits = '0;
          else nxt_recBits = recBits_ff + 1'b1;
        end
        if (idleEvt) begin
          nxt_idles = idles_ff + 1'b1;
          nxt_rec   = satInc(rec_ff);             // idle count readable in the rx counter
          nxt_lec   = LEC_BIT0_ERROR;
        end
        // idle 129 done; the 1420th bit closes the sequence
        if (idles_ff == CNT_MAX && bitTick) begin
          nxt_state  = ST_SETTLE;
          nxt_busoff = 1'b0;
          nxt_tec    = CNT_ZERO;
          nxt_rec    = CNT_ZERO;
        end
      end
      ST_SETTLE: begin
        if (bitTick) begin                        // idle one bit after bus-off clears
          nxt_state = ST_IDLE;
          nxt_act   = ACT_IDLE;
        end
      end
      default: begin
        nxt_state = ST_HALTED;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff   <= ST_ACTIVE;
      hold_ff    <= 1'b0;
      busoff_ff  <= 1'b0;
      act_ff     <= ACT_SYNC;
      lec_ff     <= LEC_NONE;
      tec_ff     <= CNT_ZERO;
      rec_ff     <= CNT_ZERO;
      recBits_ff <= '0;
      idles_ff   <= '0;
      txPend_ff  <= 1'b0;
      txStart_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      hold_ff    <= nxt_hold;
      busoff_ff  <= nxt_busoff;
      act_ff     <= nxt_act;
      lec_ff     <= nxt_lec;
      tec_ff     <= nxt_tec;
      rec_ff     <= nxt_rec;
      recBits_ff <= nxt_recBits;
      idles_ff   <= nxt_idles;
      txPend_ff  <= nxt_txPend;
      txStart_ff <= nxt_txStart;
    end
  end

  // interrupt flags: set beats a same-cycle clear on the protocol error flag, request only on a rising flag
  always_comb begin
    nxt_pea    = idleEvt | (pea_ff & ~peIrqClear);
    nxt_peaIrq = nxt_pea & ~pea_ff & protocol_error_irq_enable;
    // the timeout flag is the exception: clear wins over a set
    nxt_rto    = ~rxTimeoutClear & (rto_ff | rxTimeoutSet);
  end

  // flag registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pea_ff    <= 1'b0;
      rto_ff    <= 1'b0;
      peaIrq_ff <= 1'b0;
    end else begin
      pea_ff    <= nxt_pea;
      rto_ff    <= nxt_rto;
      peaIrq_ff <= nxt_peaIrq;
    end
  end

  // outputs; receive path closed whenever the block is not on the bus
  assign rxMsgAccept             = rxMsgValid && (state_ff == ST_BUSY) && (act_ff == ACT_RX);
  assign txStart                 = txStart_ff;
  assign init_hold               = hold_ff;
  // one driver for the whole status word, so no field is left to a second assignment
  assign status                  = '{busoffFlag:       busoff_ff,
                                     busActivityState: act_ff,
                                     lastErrorCode:    lec_ff,
                                     rxErrorCount:     rec_ff,
                                     txErrorCount:     tec_ff};
  assign protocol_error_irq_flag = pea_ff;
  assign rx_timeout_event        = rto_ff;
  assign irqRequest              = peaIrq_ff;

  // assertions
  property p_busoff_hold;
    @(posedge sys_clk) disable iff (reset)
      $rose(busoff_ff) |-> hold_ff && act_ff == ACT_SYNC;
  endproperty
  a_busoff_hold: assert property (p_busoff_hold) else $error("bus-off without hold");

  property p_halt_until_clear;
    @(posedge sys_clk) disable iff (reset)
      state_ff == ST_HALTED && !initHoldClear |=> state_ff == ST_HALTED;
  endproperty
  a_halt_until_clear: assert property (p_halt_until_clear) else $error("left halt without clear");

  property p_recover_sync;
    @(posedge sys_clk) disable iff (reset)
      recovering |-> busoff_ff && act_ff == ACT_SYNC;
  endproperty
  a_recover_sync: assert property (p_recover_sync) else $error("recovery status wrong");

  property p_idle_lec;
    @(posedge sys_clk) disable iff (reset)
      idleEvt |=> lec_ff == LEC_BIT0_ERROR && pea_ff && rec_ff == satInc($past(rec_ff));
  endproperty
  a_idle_lec: assert property (p_idle_lec) else $error("idle event not flagged");

  property p_no_rx;
    @(posedge sys_clk) disable iff (reset)
      busoff_ff |-> !rxMsgAccept;
  endproperty
  a_no_rx: assert property (p_no_rx) else $error("message accepted in bus-off");

  property p_tx_idle;
    @(posedge sys_clk) disable iff (reset)
      txStart |-> $past(act_ff) == ACT_IDLE && !busoff_ff;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("tx started outside idle");

  property p_complete;
    @(posedge sys_clk) disable iff (reset)
      $fell(busoff_ff) |-> tec_ff == CNT_ZERO && rec_ff == CNT_ZERO && state_ff == ST_SETTLE;
  endproperty
  a_complete: assert property (p_complete) else $error("counters not cleared at end");

  property p_set_wins;
    @(posedge sys_clk) disable iff (reset)
      idleEvt && peIrqClear |=> pea_ff;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set");

  property p_edge_irq;
    @(posedge sys_clk) disable iff (reset)
      irqRequest |-> pea_ff && !$past(pea_ff);
  endproperty
  a_edge_irq: assert property (p_edge_irq) else $error("request without rising flag");

  property p_busoff_entry;
    @(posedge sys_clk) disable iff (reset)
      !busoff_ff && txErrInc && tec_ff == TEC_LIM |=> busoff_ff && hold_ff && state_ff == ST_HALTED;
  endproperty
  a_busoff_entry: assert property (p_busoff_entry) else $error("no bus-off past the limit");

  property p_dom_restart;
    @(posedge sys_clk) disable iff (reset)
      recovering && bitTick && !rxBit |=> recBits_ff == '0 && busoff_ff;
  endproperty
  a_dom_restart: assert property (p_dom_restart) else $error("idle run not restarted");

  property p_busoff_end;
    @(posedge sys_clk) disable iff (reset)
      $fell(busoff_ff) |-> $past(idles_ff) == CNT_MAX && $past(bitTick);
  endproperty
  a_busoff_end: assert property (p_busoff_end) else $error("bus-off left too early");

  property p_idle_hold;
    @(posedge sys_clk) disable iff (reset)
      state_ff == ST_IDLE && !bitTick && !txErrInc |=> state_ff == ST_IDLE && act_ff == ACT_IDLE;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle left inside a bit");

  property p_rto_clear;
    @(posedge sys_clk) disable iff (reset)
      rxTimeoutClear |=> !rx_timeout_event;
  endproperty
  a_rto_clear: assert property (p_rto_clear) else $error("timeout clear lost");

endmodule : cbr_busoff_recovery

// ===== verilog/cbr_pkg.sv
// package for the can bus-off recovery block: constants, enums and carriers
package cbr_pkg;

  // activity field encodings
  typedef enum logic [1:0] {
    ACT_SYNC = 2'h0,
    ACT_IDLE = 2'h1,
    ACT_RX   = 2'h2,
    ACT_TX   = 2'h3
  } cbr_act_t;

  // recovery sequencer states
  typedef enum logic [2:0] {
    ST_ACTIVE  = 3'h0,
    ST_HALTED  = 3'h1,
    ST_RECOVER = 3'h2,
    ST_SETTLE  = 3'h3,
    ST_IDLE    = 3'h4,
    ST_BUSY    = 3'h5
  } cbr_state_t;

  localparam logic [2:0] LEC_NONE       = 3'h0;
  localparam logic [2:0] LEC_BIT0_ERROR = 3'h5;
  localparam int         IDLE_BITS      = 11;   // recessive bits per bus-idle condition
  localparam int         IDLE_COUNT     = 129;  // idle conditions counted before leaving bus-off
  localparam int         BUSOFF_LIMIT   = 255;  // tx error count above this means bus-off
  localparam int         CNT_W          = 9;    // error counter width, holds 256

  // status carrier seen by software
  typedef struct packed {
    logic               busoffFlag;
    cbr_act_t           busActivityState;
    logic [2:0]         lastErrorCode;
    logic [CNT_W-1:0]   rxErrorCount;
    logic [CNT_W-1:0]   txErrorCount;
  } cbr_status_t;

endpackage : cbr_pkg
